// *** hdl/alias_remap_defs.svh ***
// register offsets, field positions and reset values for the alias remap block
`ifndef ALIAS_REMAP_DEFS_SVH
`define ALIAS_REMAP_DEFS_SVH
`define PHYS_ADDR_5_OFS 8'h62
`define PHYS_ADDR_6_OFS 8'h63
`define PHYS_ADDR_7_OFS 8'h64
`define ALIAS_ADDR_0_OFS 8'h65
`define PORT_SEL_OFS 8'h4c
`define ADDR_FIELD_MSB 7
`define ADDR_FIELD_LSB 1
`define AUTO_ACK_BIT 0
`define REG_RESET 8'h00
`define NUM_PORTS 2
`define ALIAS_SLOT_0 3'h0
`define PHYS_SLOT_5 3'h5
`define PHYS_SLOT_6 3'h6
`define PHYS_SLOT_7 3'h7
`endif

// *** hdl/alias_remap_pkg.sv ***
// types shared by the alias remap block
package alias_remap_pkg;
    typedef struct packed {
        logic [6:0] addr;
        logic auto_ack;
    } alias_slot_s;
    typedef struct packed {
        logic valid;
        logic rnw;
        logic [6:0] addr;
    } i2c_req_s;
    typedef enum logic [1:0] {ST_IDLE, ST_MATCH, ST_DONE} match_state_e;
endpackage : alias_remap_pkg

// *** hdl/alias_match.sv ***
// compares one local address against an alias slot
`timescale 1ns/10ps
module alias_match
    import alias_remap_pkg::*;
(
    input wire alias_slot_s slot,
    input wire logic [6:0] addr,
    output logic hit
);
    // zero alias never matches, so an unprogrammed slot is dead
    assign hit = (slot.addr != 7'h00) && (slot.addr == addr);
endmodule : alias_match

// *** hdl/remote_i2c_alias_remap.sv ***
// alias-to-physical address remap for remote targets, per receive port
// What this block does
// - physical-address register bits 7:1 hold the remote target's real seven-bit address.
// - on alias match, replace address with the matching port's slot 5 physical-address copy, then forward.
// - alias bits 7:1 program a decoder recognising local transactions for that target.
// - alias value zero disables matching for its slot.
// - auto-ack bit set acknowledges every write locally, ignoring lock and remote ack.
// - separate register copy per receive port, chosen by the port-select register.
`timescale 1ns/10ps
`include "alias_remap_defs.svh"
module remote_i2c_alias_remap
    import alias_remap_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire i2c_req_s LOCAL_REQ,
    input wire logic FWD_LOCK,
    input wire logic REMOTE_ACK,
    output logic [`NUM_PORTS-1:0] FWD_VALID,
    output logic [6:0] FWD_ADDR,
    output logic FWD_RNW,
    output logic LOCAL_HIT,
    output logic LOCAL_ACK
);
    logic [7:0] port_sel_ff;
    logic [7:0] phys_ff [`NUM_PORTS][3];
    alias_slot_s alias_ff [`NUM_PORTS];
    logic [7:0] rdata_ff;
    logic sel_port;
    logic [`NUM_PORTS-1:0] hit;
    logic [`NUM_PORTS-1:0] fwd_valid_ff;
    logic [6:0] fwd_addr_ff;
    logic fwd_rnw_ff;
    logic local_hit_ff;
    logic local_ack_ff;
    logic [7:0] nxt_rdata;
    logic wr_port_sel;
    logic wr_phys;
    logic wr_alias;
    logic req_hit;
    logic [`NUM_PORTS-1:0] nxt_fwd_valid;
    logic [6:0] nxt_fwd_addr;
    logic [`NUM_PORTS-1:0] ack_src;
    logic nxt_local_ack;

    // position of a physical-address copy inside one port's slot array
    function automatic logic [1:0] phys_index(input logic [7:0] ofs);
        phys_index = 2'(ofs - `PHYS_ADDR_5_OFS);
    endfunction : phys_index

    function automatic logic is_phys_ofs(input logic [7:0] ofs);
        is_phys_ofs = (ofs >= `PHYS_ADDR_5_OFS) && (ofs <= `PHYS_ADDR_7_OFS);
    endfunction : is_phys_ofs

    function automatic logic is_alias_ofs(input logic [7:0] ofs);
        is_alias_ofs = (ofs == `ALIAS_ADDR_0_OFS);
    endfunction : is_alias_ofs

    // seven-bit address field of a stored byte; bit 0 is never part of it
    function automatic logic [6:0] addr_field(input logic [7:0] value);
        addr_field = value[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
    endfunction : addr_field

    assign sel_port = port_sel_ff[0];
    assign wr_port_sel = REG_WR && (REG_ADDR == `PORT_SEL_OFS);
    assign wr_phys = REG_WR && is_phys_ofs(REG_ADDR);
    assign wr_alias = REG_WR && is_alias_ofs(REG_ADDR);
    assign req_hit = LOCAL_REQ.valid && (hit != '0);

    // port select: low bit chooses which receive port's copy the bus sees
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            port_sel_ff <= `REG_RESET;
        end else if (wr_port_sel) begin
            port_sel_ff <= REG_WDATA;
        end
    end

    // reserved bit 0 is stored as zero, so no read path can leak a written one
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            for (int p = 0; p < `NUM_PORTS; p++) begin
                for (int s = 0; s < 3; s++) begin
                    phys_ff[p][s] <= `REG_RESET;
                end
            end
        end else if (wr_phys) begin
            phys_ff[sel_port][phys_index(REG_ADDR)] <= {addr_field(REG_WDATA), 1'b0};
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            for (int p = 0; p < `NUM_PORTS; p++) begin
                alias_ff[p] <= alias_slot_s'(`REG_RESET);
            end
        end else if (wr_alias) begin
            alias_ff[sel_port] <= alias_slot_s'(REG_WDATA);
        end
    end

    // unmapped offsets read as zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (is_phys_ofs(REG_ADDR)) begin
            nxt_rdata = {addr_field(phys_ff[sel_port][phys_index(REG_ADDR)]), 1'b0};
        end else if (is_alias_ofs(REG_ADDR)) begin
            nxt_rdata = alias_ff[sel_port];
        end else if (REG_ADDR == `PORT_SEL_OFS) begin
            nxt_rdata = port_sel_ff;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            rdata_ff <= `REG_RESET;
        end else if (REG_RD) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // each port decodes against its own alias slot, independent of port select
    for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_match
        alias_match u_match (
            .slot(alias_ff[p]),
            .addr(LOCAL_REQ.addr),
            .hit(hit[p])
        );
    end

    // slot 0's physical register lies outside this block, so slot 0 remaps
    // through the slot 5 copy; a limitation until the remaining pairs are added
    always_comb begin
        nxt_fwd_valid = '0;
        nxt_fwd_addr = fwd_addr_ff;
        if (LOCAL_REQ.valid) begin
            nxt_fwd_valid = hit;
        end
        // later ports overwrite earlier ones, so port 1 wins a double hit
        for (int p = 0; p < `NUM_PORTS; p++) begin
            if (LOCAL_REQ.valid && hit[p]) begin
                nxt_fwd_addr = addr_field(phys_ff[p][0]);
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            fwd_valid_ff <= '0;
        end else begin
            fwd_valid_ff <= nxt_fwd_valid;
        end
    end

    // address and direction hold between hits for the forwarding side
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            fwd_addr_ff <= 7'h00;
        end else begin
            fwd_addr_ff <= nxt_fwd_addr;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            fwd_rnw_ff <= 1'b0;
        end else if (req_hit) begin
            fwd_rnw_ff <= LOCAL_REQ.rnw;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            local_hit_ff <= 1'b0;
        end else begin
            local_hit_ff <= req_hit;
        end
    end

    // auto-ack bypasses lock and remote acknowledge for writes only;
    // a read still needs the far side, since only it can supply the data
    always_comb begin
        for (int p = 0; p < `NUM_PORTS; p++) begin
            ack_src[p] = 1'b0;
            if (LOCAL_REQ.valid && hit[p]) begin
                if (!LOCAL_REQ.rnw && alias_ff[p].auto_ack) begin
                    ack_src[p] = 1'b1;
                end else if (FWD_LOCK && REMOTE_ACK) begin
                    ack_src[p] = 1'b1;
                end
            end
        end
        nxt_local_ack = (ack_src != '0);
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            local_ack_ff <= 1'b0;
        end else begin
            local_ack_ff <= nxt_local_ack;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign FWD_VALID = fwd_valid_ff;
    assign FWD_ADDR = fwd_addr_ff;
    assign FWD_RNW = fwd_rnw_ff;
    assign LOCAL_HIT = local_hit_ff;
    assign LOCAL_ACK = local_ack_ff;
endmodule : remote_i2c_alias_remap

// *** test/serializer_model.sv ***
// far-side serializer: lock level and remote acknowledge
`timescale 1ns/10ps
module serializer_model (
    input wire logic CORE_CLK,
    input wire logic up,
    input wire logic refuse,
    output logic FWD_LOCK,
    output logic REMOTE_ACK
);
    // never acks while unlinked
    always_ff @(posedge CORE_CLK) begin
        FWD_LOCK <= up;
        REMOTE_ACK <= up && !refuse;
    end
endmodule : serializer_model

// *** test/alias_remap_props.sv ***
// port assertions for the alias remap block
`timescale 1ns/10ps
module alias_remap_props
    import alias_remap_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_RDATA,
    input wire i2c_req_s LOCAL_REQ,
    input wire logic FWD_LOCK,
    input wire logic REMOTE_ACK,
    input wire logic [1:0] FWD_VALID,
    input wire logic [6:0] FWD_ADDR,
    input wire logic FWD_RNW,
    input wire logic LOCAL_HIT,
    input wire logic LOCAL_ACK
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    hit_cause_a: assert property (LOCAL_HIT |-> $past(LOCAL_REQ.valid))
        else $error("hit");
    fwd_hit_a: assert property ((FWD_VALID != 2'h0) == LOCAL_HIT)
        else $error("fwd");
    ack_hit_a: assert property (LOCAL_ACK |-> LOCAL_HIT) else $error("ack");
    ack_lock_a: assert property (LOCAL_HIT && $past(FWD_LOCK && REMOTE_ACK) |-> LOCAL_ACK)
        else $error("lock");
    zero_alias_a: assert property (LOCAL_REQ.valid && LOCAL_REQ.addr == 7'h00 |=> !LOCAL_HIT)
        else $error("zero");
    fwd_rnw_a: assert property (LOCAL_HIT |-> FWD_RNW == $past(LOCAL_REQ.rnw))
        else $error("rnw");
    // reset clears the address, so skip the edge after it
    addr_hold_a: assert property (!LOCAL_HIT && !$past(SRST) |-> $stable(FWD_ADDR))
        else $error("hold");
    phys_bit0_a: assert property (REG_RD && REG_ADDR inside {8'h62, 8'h63, 8'h64} |=>
        !REG_RDATA[0]) else $error("bit0");
endmodule : alias_remap_props
bind remote_i2c_alias_remap alias_remap_props u_props(.*);

// *** test/remote_i2c_alias_remap_tb.sv ***
// register and remap tests for the alias remap block
`timescale 1ns/10ps
module remote_i2c_alias_remap_tb;
    import alias_remap_pkg::*;
    logic CORE_CLK = 0, SRST = 1, REG_WR = 0, REG_RD = 0, up = 0, refuse = 0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
    i2c_req_s LOCAL_REQ = '0;
    logic FWD_LOCK, REMOTE_ACK, FWD_RNW, LOCAL_HIT, LOCAL_ACK;
    logic [1:0] FWD_VALID;
    logic [6:0] FWD_ADDR;
    int n_fail = 0, compares = 0, cyc = 0;
    always #4 CORE_CLK = ~CORE_CLK;
    remote_i2c_alias_remap u_dut(
        .CORE_CLK(CORE_CLK),
        .SRST(SRST),
        .REG_WR(REG_WR),
        .REG_RD(REG_RD),
        .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA),
        .LOCAL_REQ(LOCAL_REQ),
        .FWD_LOCK(FWD_LOCK),
        .REMOTE_ACK(REMOTE_ACK),
        .FWD_VALID(FWD_VALID),
        .FWD_ADDR(FWD_ADDR),
        .FWD_RNW(FWD_RNW),
        .LOCAL_HIT(LOCAL_HIT),
        .LOCAL_ACK(LOCAL_ACK)
    );
    serializer_model u_ser(.CORE_CLK, .up, .refuse, .FWD_LOCK, .REMOTE_ACK);
    task automatic end_of_test;
        $display("fails %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [11:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        @(posedge CORE_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        @(posedge CORE_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1 chk({4'h0, REG_RDATA}, {4'h0, e});
    endtask : rd
    // result packs port, hit, ack, rnw and address
    task automatic rq(input logic rnw, input logic [6:0] a, input logic [11:0] e);
        @(posedge CORE_CLK);
        LOCAL_REQ <= {1'b1, rnw, a};
        @(posedge CORE_CLK);
        LOCAL_REQ <= '0;
        #1 chk({FWD_VALID, LOCAL_HIT, LOCAL_ACK, FWD_RNW, FWD_ADDR}, e);
    endtask : rq
    always @(posedge CORE_CLK) if (++cyc > 2000) begin
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge CORE_CLK);
        SRST <= 1'b0;
        for (int a = 8'h62; a <= 8'h65; a++) rd(a[7:0], 8'h00);
        wr(8'h4c, 8'h00);
        wr(8'h62, 8'hff);
        wr(8'h63, 8'ha5);
        wr(8'h70, 8'hff);
        rd(8'h62, 8'hfe);
        rd(8'h63, 8'ha4);
        rd(8'h70, 8'h00);
        rq(1'b0, 7'h00, 12'h000);
        wr(8'h65, 8'h55);
        rq(1'b0, 7'h2a, 12'h77f);
        rq(1'b1, 7'h2a, 12'h6ff);
        wr(8'h65, 8'h54);
        rq(1'b0, 7'h2a, 12'h67f);
        rq(1'b0, 7'h2b, 12'h07f);
        wr(8'h4c, 8'h01);
        rd(8'h65, 8'h00);
        wr(8'h65, 8'h56);
        wr(8'h62, 8'h22);
        up <= 1'b1;
        rq(1'b1, 7'h2b, 12'hb91);
        rq(1'b0, 7'h2a, 12'h77f);
        refuse <= 1'b1;
        rq(1'b0, 7'h2a, 12'h67f);
        wr(8'h4c, 8'h00);
        rd(8'h65, 8'h54);
        end_of_test();
    end
endmodule : remote_i2c_alias_remap_tb
